//--- logic/ebs_pkg.sv
// Purpose: constants for the external bus cycle sequencer
// Assumes: one phase time unit equals one clock period
// Notes: chip select count and field widths are fixed
package ebs_pkg;
	localparam int CS_NUM = 4;
	localparam int CS_W = 2;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	// per chip select timing word layout
	localparam int AB_POS = 0;
	localparam int AB_W = 1;
	localparam int ABX_POS = 1;
	localparam int ABX_W = 2;
	localparam int C_POS = 3;
	localparam int C_W = 2;
	localparam int D_POS = 5;
	localparam int E_POS = 6;
	localparam int E_W = 5;
	localparam int F_POS = 11;
	localparam int F_W = 2;
	localparam int RDYEN_POS = 13;
	localparam int RDYPOL_POS = 14;
	localparam int RDYASYNC_POS = 15;
	localparam int CFG_W = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	// phase time unit in ns and cycles at 125 MHz
	localparam int CLK_PERIOD_NS = 8;
	localparam int PHASE_UNIT_NS = 8;
	localparam int PHASE_UNIT_CYC = (PHASE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {ST_IDLE, ST_AB, ST_C, ST_D, ST_E, ST_RDY, ST_F} ebs_state_e;
endpackage

//--- logic/ebs_sequencer.sv
// Purpose: runs external bus cycles through five timed phases
// Assumes: ready input is a pin; request side is on the same clock
// Notes: phase unit is one clock period, so PHASE_UNIT_CYC is 1
`timescale 1ns/1ns
module ebs_sequencer (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic mux_mode_i,
	input wire logic [ebs_pkg::CS_NUM*ebs_pkg::CFG_W-1:0] chip_select_timing_cfg_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic [ebs_pkg::CS_W-1:0] req_cs_i,
	input wire logic [ebs_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [ebs_pkg::DATA_W-1:0] req_wdata_i,
	input wire logic [1:0] req_be_i,
	output logic done_o,
	output logic [ebs_pkg::DATA_W-1:0] rdata_o,
	input wire logic ready_i,
	output logic [ebs_pkg::ADDR_W-1:0] address_lines_o,
	output logic [ebs_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_n_o,
	input wire logic [ebs_pkg::DATA_W-1:0] data_lines_i,
	output logic [ebs_pkg::DATA_W-1:0] shared_addr_data_lines_o,
	output logic shared_addr_data_lines_oe_n_o,
	input wire logic [ebs_pkg::DATA_W-1:0] shared_addr_data_lines_i,
	output logic rd_n_o,
	output logic wr_low_n_o,
	output logic wr_high_n_o,
	output logic high_byte_enable_n_o,
	output logic addr_latch_en_o,
	output logic [ebs_pkg::CS_NUM-1:0] cs_n_o
);
	import ebs_pkg::*;
	// reset release through two flops
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end
	// three-stage pin synchroniser for ready; stage one read only by stage two
	logic rdy_s1_reg;
	logic rdy_s2_reg;
	logic rdy_s3_reg;
	logic rdy_async_reg;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
			rdy_s3_reg <= 1'b0;
			rdy_async_reg <= 1'b0;
		end else if (clk_en_i) begin
			rdy_s1_reg <= ready_i;
			rdy_s2_reg <= rdy_s1_reg;
			rdy_s3_reg <= rdy_s2_reg;
			// level taken only once stages two and three agree
			if (rdy_s2_reg == rdy_s3_reg) begin
				rdy_async_reg <= rdy_s3_reg;
			end
		end
	end

	// pick one chip select's timing word
	function automatic logic [CFG_W-1:0] cfg_of(input logic [CS_NUM*CFG_W-1:0] all, input logic [CS_W-1:0] cs);
		cfg_of = all[cs*CFG_W +: CFG_W];
	endfunction
	ebs_state_e state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CFG_W-1:0] cfg_reg, cfg_next;
	logic write_reg, write_next;
	logic [CS_W-1:0] cs_reg, cs_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [ADDR_W-1:0] last_addr_reg, last_addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [1:0] be_reg, be_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic done_reg, done_next;
	logic first_reg, first_next;
	logic [CNT_W-1:0] ab_len;
	logic [CFG_W-1:0] new_cfg;
	// ready as seen by the sequencer, polarity and mode per chip select
	// polarity select, async extra stage
	wire logic ready_seen = (cfg_reg[RDYASYNC_POS] ? rdy_async_reg : rdy_s3_reg) ^ cfg_reg[RDYPOL_POS];

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cfg_next = cfg_reg;
		write_next = write_reg;
		cs_next = cs_reg;
		addr_next = addr_reg;
		last_addr_next = last_addr_reg;
		wdata_next = wdata_reg;
		be_next = be_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		first_next = first_reg;
		new_cfg = cfg_of(chip_select_timing_cfg_i, req_cs_i);
		ab_len = CNT_ONE + CNT_W'(new_cfg[AB_POS +: AB_W]);
		if (first_reg || req_addr_i[ADDR_W-1:16] != last_addr_reg[ADDR_W-1:16]) begin
			ab_len = ab_len + CNT_W'(new_cfg[ABX_POS +: ABX_W]);
		end
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					cfg_next = new_cfg;
					write_next = req_write_i;
					cs_next = req_cs_i;
					addr_next = req_addr_i;
					wdata_next = req_wdata_i;
					be_next = req_be_i;
					cnt_next = ab_len - CNT_W'(PHASE_UNIT_CYC);
					state_next = ST_AB;
				end
			end
			// fixed phase order; zero C, D and F phases skipped, E runs at least one cycle
			ST_AB: begin
				if (cnt_reg != CNT_ZERO) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else if (cfg_reg[C_POS +: C_W] != 2'h0) begin
					cnt_next = CNT_W'(cfg_reg[C_POS +: C_W]) - CNT_ONE;
					state_next = ST_C;
				end else if (cfg_reg[D_POS]) begin
					cnt_next = CNT_ZERO;
					state_next = ST_D;
				end else begin
					cnt_next = cfg_reg[E_POS +: E_W];
					state_next = ST_E;
				end
			end
			ST_C: begin
				if (cnt_reg != CNT_ZERO) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else if (cfg_reg[D_POS]) begin
					state_next = ST_D;
				end else begin
					cnt_next = cfg_reg[E_POS +: E_W];
					state_next = ST_E;
				end
			end
			ST_D: begin
				cnt_next = cfg_reg[E_POS +: E_W];
				state_next = ST_E;
			end
			ST_E: begin
				if (cnt_reg != CNT_ZERO) begin
					cnt_next = cnt_reg - CNT_ONE;
				end else if (cfg_reg[RDYEN_POS] && !ready_seen) begin
					state_next = ST_RDY;
				end else begin
					state_next = ST_F;
				end
			end
			ST_RDY: begin
				if (ready_seen) begin
					state_next = ST_F;
				end
			end
			ST_F: begin
				cnt_next = cnt_reg - CNT_ONE;
				if (cnt_reg <= CNT_ONE) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// leaving access: capture on strobe rise; nothing later used
		if ((state_reg == ST_E || state_reg == ST_RDY) && state_next == ST_F) begin
			if (!write_reg) begin
				rdata_next = mux_mode_i ? shared_addr_data_lines_i : data_lines_i;
			end
			// hold length; zero ends the cycle at once
			cnt_next = CNT_W'(cfg_reg[F_POS +: F_W]);
			if (cfg_reg[F_POS +: F_W] == 2'h0) begin
				state_next = ST_IDLE;
			end
		end
		// cycle end: pulse done, remember the address window
		if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
			done_next = 1'b1;
			last_addr_next = addr_reg;
			first_next = 1'b0;
		end
	end
	// state registers; clock enable freezes all
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= CNT_ZERO;
			cfg_reg <= '0;
			write_reg <= 1'b0;
			cs_reg <= '0;
			addr_reg <= '0;
			last_addr_reg <= '0;
			wdata_reg <= '0;
			be_reg <= 2'h0;
			rdata_reg <= '0;
			done_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if (clk_en_i) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cfg_reg <= cfg_next;
			write_reg <= write_next;
			cs_reg <= cs_next;
			addr_reg <= addr_next;
			last_addr_reg <= last_addr_next;
			wdata_reg <= wdata_next;
			be_reg <= be_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
			first_reg <= first_next;
		end
	end

	// pin outputs registered from next state so they align with phases
	wire logic in_cycle_next = state_next != ST_IDLE;
	wire logic in_access_next = state_next == ST_E || state_next == ST_RDY;
	wire logic data_phase_next = state_next == ST_D || in_access_next || state_next == ST_F;

	// pins come straight from flops, no second copy
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			address_lines_o <= '0;
			data_lines_o <= '0;
			data_lines_oe_n_o <= 1'b1;
			shared_addr_data_lines_o <= '0;
			shared_addr_data_lines_oe_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			wr_low_n_o <= 1'b1;
			wr_high_n_o <= 1'b1;
			high_byte_enable_n_o <= 1'b1;
			addr_latch_en_o <= 1'b0;
			cs_n_o <= '1;
		end else if (clk_en_i) begin
			// separate address; read data comes from the strobe-rise edge, not address
			address_lines_o <= in_cycle_next ? addr_next : address_lines_o;
			data_lines_o <= wdata_next;
			data_lines_oe_n_o <= !(in_cycle_next && write_next && !mux_mode_i);
			// address in setup, write data later
			shared_addr_data_lines_o <= (state_next == ST_AB || state_next == ST_C)
				? addr_next[DATA_W-1:0] : wdata_next;
			shared_addr_data_lines_oe_n_o <= !(mux_mode_i && in_cycle_next
				&& (state_next == ST_AB || state_next == ST_C || (write_next && data_phase_next)));
			rd_n_o <= !(in_access_next && !write_next);
			wr_low_n_o <= !(in_access_next && write_next && be_next[0]);
			wr_high_n_o <= !(in_access_next && write_next && be_next[1]);
			high_byte_enable_n_o <= !(in_cycle_next && be_next[1]);
			addr_latch_en_o <= mux_mode_i && state_next == ST_AB;
			for (int i = 0; i < CS_NUM; i++) begin
				cs_n_o[i] <= !(in_cycle_next && cs_next == CS_W'(i));
			end
		end
	end

	// handshake and data outputs; no take while the inner reset still holds the flops
	assign req_ready_o = rst_n && state_reg == ST_IDLE;
	assign done_o = done_reg;
	assign rdata_o = rdata_reg;
endmodule

//--- tb/ebs_properties.sv
// Purpose: pin checks for the sequencer
// Assumes: clk_en_i held high
// Notes: bound into each sequencer
`timescale 1ns/1ns
module ebs_properties (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic mux_mode_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic done_o,
	input wire logic [15:0] rdata_o,
	input wire logic [15:0] data_lines_i,
	input wire logic data_lines_oe_n_o,
	input wire logic rd_n_o,
	input wire logic wr_low_n_o,
	input wire logic wr_high_n_o,
	input wire logic addr_latch_en_o,
	input wire logic [3:0] cs_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// any strobe low
	wire logic stb = !rd_n_o || !wr_low_n_o || !wr_high_n_o;
	// strobes, selects and timing of the cycle end
	AST_ONE_CS: assert property ($onehot0(~cs_n_o))
		else $error("two selects");
	AST_STB_CS: assert property (stb |-> cs_n_o != 4'hF)
		else $error("strobe unselected");
	AST_RD_WR: assert property (!rd_n_o |-> wr_low_n_o && wr_high_n_o)
		else $error("read with write");
	AST_ALE: assert property (addr_latch_en_o |-> mux_mode_i && !stb)
		else $error("latch misplaced");
	AST_DONE: assert property (done_o |=> !done_o)
		else $error("done too long");
	AST_END: assert property (req_valid_i && req_ready_o |-> ##[2:90] done_o)
		else $error("no cycle end");
	AST_RDATA: assert property (!mux_mode_i && $rose(rd_n_o) |-> rdata_o == $past(data_lines_i))
		else $error("read data late");
	AST_WDRV: assert property (!mux_mode_i && stb && rd_n_o |-> !data_lines_oe_n_o)
		else $error("write undriven");
endmodule
bind ebs_sequencer ebs_properties u_props (.ref_clk_i, .arst_n_i, .mux_mode_i, .req_valid_i, .req_ready_o,
	.done_o, .rdata_o, .data_lines_i, .data_lines_oe_n_o, .rd_n_o, .wr_low_n_o, .wr_high_n_o,
	.addr_latch_en_o, .cs_n_o);

//--- tb/ebs_bus_model.sv
// Purpose: memory device on the bus
// Assumes: low address byte picks a word
// Notes: ready delay and polarity from bench
`timescale 1ns/1ns
module ebs_bus_model (
	input wire logic clk_i,
	input wire logic mux_i,
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wl_n_i,
	input wire logic wh_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] sh_i,
	input wire logic [15:0] wd_i,
	input wire logic pol_i,
	input wire logic [3:0] dly_i,
	output logic [15:0] q_o,
	output logic ready_o
);
	logic [15:0] mem [256];
	logic [15:0] last_reg = '0;
	logic [7:0] lat_reg = '0;
	logic [3:0] cnt_reg = '0;
	wire logic act = !rd_n_i || !wl_n_i || !wh_n_i;
	wire logic [7:0] idx = mux_i ? lat_reg : addr_i;
	initial foreach (mem[k]) mem[k] = '0;
	assign q_o = rd_n_i ? ~last_reg : mem[idx];
	assign ready_o = (act && cnt_reg >= dly_i) ^ pol_i;
	// latch address, count strobe, take bytes
	always @(posedge clk_i) begin
		if (ale_i)
			lat_reg <= sh_i[7:0];
		cnt_reg <= act ? cnt_reg + {3'h0, cnt_reg != 4'hF} : 4'h0;
		if (!rd_n_i)
			last_reg <= mem[idx];
		if (!wl_n_i)
			mem[idx][7:0] <= wd_i[7:0];
		if (!wh_n_i)
			mem[idx][15:8] <= wd_i[15:8];
	end
endmodule

//--- tb/ebs_sequencer_tb_top.sv
// Purpose: random bus cycles on a memory model
// Assumes: one phase unit per clock
// Notes: timing words change between cycles
`timescale 1ns/1ns
module ebs_sequencer_tb_top;
	localparam int OPS = 300;
	logic clk = 0, rst_n = 0, mux = 0, vld = 0, wr = 0, first = 1;
	logic [63:0] cfg = '0;
	logic [1:0] cs = '0, be = '0;
	logic [23:0] adr = '0, a_o;
	logic [15:0] wd = '0, w = '0, q, d_o, s_o, rdata, shadow [256];
	logic [7:0] prev_hi = '0;
	logic [3:0] dly = '0, cs_n;
	logic ack, done, d_oe_n, s_oe_n, rd_n, wl_n, wh_n, bhe_n, ale, rdy;
	int seed = 32'h6f396820, n_fail = 0, tests_run = 0;
	wire logic [15:0] d_bus = d_oe_n ? q : d_o;
	wire logic [15:0] s_bus = s_oe_n ? q : s_o;
	ebs_sequencer dut (.ref_clk_i(clk), .arst_n_i(rst_n), .clk_en_i(1'b1), .mux_mode_i(mux),
		.chip_select_timing_cfg_i(cfg), .req_valid_i(vld), .req_ready_o(ack), .req_write_i(wr), .req_cs_i(cs),
		.req_addr_i(adr), .req_wdata_i(wd), .req_be_i(be), .done_o(done), .rdata_o(rdata), .ready_i(rdy),
		.address_lines_o(a_o), .data_lines_o(d_o), .data_lines_oe_n_o(d_oe_n), .data_lines_i(d_bus),
		.shared_addr_data_lines_o(s_o), .shared_addr_data_lines_oe_n_o(s_oe_n), .shared_addr_data_lines_i(s_bus),
		.rd_n_o(rd_n), .wr_low_n_o(wl_n), .wr_high_n_o(wh_n), .high_byte_enable_n_o(bhe_n),
		.addr_latch_en_o(ale), .cs_n_o(cs_n));
	ebs_bus_model bm (.clk_i(clk), .mux_i(mux), .ale_i(ale), .rd_n_i(rd_n), .wl_n_i(wl_n), .wh_n_i(wh_n),
		.addr_i(a_o[7:0]), .sh_i(s_bus), .wd_i(mux ? s_bus : d_bus), .pol_i(w[14]), .dly_i(dly),
		.q_o(q), .ready_o(rdy));
	always #4 clk = ~clk;
	task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %0h want %0h", $time, msg, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// setup: base, window extension, delay, data setup
	function automatic int setup_len(logic [15:0] c, logic x);
		return 1 + c[0] + (x ? c[2:1] : 2'h0) + c[4:3] + c[5];
	endfunction
	// one cycle; words 0 and 1 are all-min and all-max timing corners, ready bits off in both
	task automatic run_op(int i);
		int t, phase_time_unit = 0, tst = 0, tsr = 0, e;
		for (t = 0; t < 20 && !ack; t++)
			@(posedge clk) #1;
		cfg = {$random(seed), $random(seed)};
		cs = 2'($random(seed));
		w = i == 0 ? 16'h0000 : i == 1 ? 16'h1FFF : 16'($random(seed));
		cfg[cs*16 +: 16] = w;
		mux = 1'($random(seed));
		wr = 1'($random(seed));
		adr = {7'h00, 1'($random(seed)), 12'h000, 4'($random(seed))};
		wd = 16'($random(seed));
		be = 2'({$random(seed)} % 3 + 1);
		dly = 4'({$random(seed)} % 8);
		// stale ready or a polarity flip must leave the synchroniser first
		if (w[13])
			repeat (6) @(posedge clk) #1;
		vld = 1;
		@(posedge clk) #1;
		vld = 0;
		for (t = 1; t < 150 && !done; t++) begin
			if (!cs_n[cs] && phase_time_unit == 0)
				phase_time_unit = t;
			if (ale)
				check(s_o, adr[15:0], "mux address");
			if (!(rd_n && wl_n && wh_n) && tst == 0) begin
				tst = t;
				check({rd_n, bhe_n, wh_n, wl_n}, {wr, ~be[1], wr ? ~be : 2'h3}, "strobes");
				if (!mux)
					check(a_o, adr, "address");
			end
			if (rd_n && wl_n && wh_n && tst != 0 && tsr == 0)
				tsr = t;
			@(posedge clk) #1;
		end
		if (tsr == 0)
			tsr = t;
		e = w[10:6] + 1;
		check(done, 1'b1, "done");
		check(phase_time_unit, 1, "select");
		check(tst - phase_time_unit, setup_len(w, first || adr[23:16] != prev_hi), "setup");
		if (w[13])
			check(tsr - tst, e > dly + 4 + w[15] ? e : dly + 4 + w[15], "ready wait");
		else
			check(tsr - tst, e, "access");
		check(t - tsr, w[12:11], "hold");
		check(cs_n, 4'hF, "release");
		if (!wr)
			check(rdata, shadow[adr[7:0]], "read data");
		if (wr && be[0])
			shadow[adr[7:0]][7:0] = wd[7:0];
		if (wr && be[1])
			shadow[adr[7:0]][15:8] = wd[15:8];
		prev_hi = adr[23:16];
		first = 0;
	endtask
	// watchdog, about 100 clocks per cycle
	initial begin
		#(OPS * 800);
		n_fail++;
		final_report();
	end
	// reset, then back-to-back random cycles
	initial begin
		foreach (shadow[k])
			shadow[k] = '0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1;
		for (int i = 0; i < OPS; i++) begin
			run_op(i);
			$display("op %0d done", i);
		end
		final_report();
	end
endmodule
